// [rtl/cmd_map_pkg.sv]
// constants for the power module command-code register bank
package cmd_map_pkg;
   localparam logic [7:0]  CODE_OT_FAULT_ACTION  = 8'h50;
   localparam logic [7:0]  CODE_OT_WARN_LEVEL    = 8'h51;
   localparam logic [7:0]  CODE_UT_WARN_LEVEL    = 8'h52;
   localparam logic [7:0]  CODE_UT_FAULT_LEVEL   = 8'h53;
   localparam logic [7:0]  CODE_UT_FAULT_ACTION  = 8'h54;
   localparam logic [7:0]  CODE_VIN_OV_FAULT_LVL = 8'h55;
   localparam logic [7:0]  CODE_VIN_OV_FAULT_ACT = 8'h56;
   localparam logic [7:0]  CODE_VIN_OV_WARN_LVL  = 8'h57;
   localparam logic [7:0]  CODE_VIN_UV_WARN_LVL  = 8'h58;
   localparam logic [7:0]  CODE_VIN_UV_FAULT_LVL = 8'h59;
   localparam logic [7:0]  CODE_VIN_UV_FAULT_ACT = 8'h5A;
   localparam logic [7:0]  CODE_GOOD_THRESHOLD   = 8'h5E;
   localparam logic [7:0]  CODE_TURN_ON_DELAY_TIME_TIME   = 8'h60;
   localparam logic [7:0]  CODE_TON_RAMP_TIME    = 8'h61;
   localparam logic [7:0]  CODE_TURN_OFF_DELAY_TIME_TIME  = 8'h64;
   localparam logic [7:0]  CODE_TOFF_RAMP_TIME   = 8'h65;
   localparam logic [7:0]  CODE_SHORT_STATUS     = 8'h78;
   localparam logic [7:0]  CODE_FULL_STATUS      = 8'h79;
   localparam logic [7:0]  CODE_VOUT_FLAGS       = 8'h7A;
   localparam logic [7:0]  CODE_IOUT_FLAGS       = 8'h7B;
   localparam logic [7:0]  CODE_INPUT_FLAGS      = 8'h7C;
   localparam logic [7:0]  CODE_THERMAL_FLAGS    = 8'h7D;
   localparam logic [7:0]  CODE_CML_FLAGS        = 8'h7E;
   localparam logic [7:0]  CODE_DRV_SYNC_FLAGS   = 8'h80;
   localparam logic [7:0]  CODE_VIN_READING      = 8'h88;
   localparam logic [7:0]  CODE_VOUT_READING     = 8'h8B;
   localparam logic [7:0]  CODE_IOUT_READING     = 8'h8C;
   localparam logic [7:0]  CODE_VOUT_MODE        = 8'h20;
   localparam logic [7:0]  CODE_CLEAR_FAULTS     = 8'h03;

   localparam logic [7:0]  RST_FAULT_ACTION      = 8'h80;
   localparam logic [15:0] RST_OT_WARN_LEVEL     = 16'hEB70;
   localparam logic [15:0] RST_UT_WARN_LEVEL     = 16'hDC40;
   localparam logic [15:0] RST_UT_FAULT_LEVEL    = 16'hE530;
   localparam logic [15:0] RST_VIN_OV_FAULT_LVL  = 16'hD3A0;
   localparam logic [15:0] RST_VIN_OV_WARN_LVL   = 16'hD34D;
   localparam logic [15:0] RST_RAMP_TIME         = 16'hCA80;
   localparam logic [15:0] RST_WORD_ZERO         = 16'h0000;
   localparam logic [7:0]  RST_BYTE_ZERO         = 8'h00;
   localparam logic [7:0]  VOUT_MODE_VALUE       = 8'h13;

   // linear-11 field layout
   localparam int L11_EXP_MSB = 15;
   localparam int L11_EXP_LSB = 11;
   localparam int L11_MAN_MSB = 10;
   localparam int MAN_W       = 11;
   // strap default scaling: 1.10 = 11/10, 0.9 = 9/10
   localparam logic [4:0]  UV_WARN_NUM = 5'h0B;
   localparam logic [4:0]  PG_NUM      = 5'h09;
   localparam logic [4:0]  SCALE_DEN   = 5'h0A;

   localparam int NUM_FLAG_GROUPS = 6;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
endpackage : cmd_map_pkg

// [rtl/flag_bus_if.sv]
// interface carrying sticky flag group events and clear between modules
`timescale 1ns/10ps
interface flag_bus_if;
   logic [cmd_map_pkg::NUM_FLAG_GROUPS*8-1:0] events;
   logic                                      clear;
   logic [cmd_map_pkg::NUM_FLAG_GROUPS*8-1:0] flags;
   modport bank (output events, output clear, input flags);
   modport hold (input events, input clear, output flags);
endinterface : flag_bus_if

// [rtl/power_module_command_map.sv]
// command-code register bank with status, limits, timing and telemetry
// Behaviour
// R1 - byte at 50h selects over-temperature fault action, resets to 80h
// R2 - over-temperature warning word at 51h, resets to EB70h
// R3 - under-temperature warning word at 52h, resets to DC40h
// R4 - under-temperature fault word at 53h, resets to E530h
// R5 - byte at 54h selects under-temperature fault action, resets to 80h
// R6 - input overvoltage warning word at 57h, resets to D34Dh
// R7 - input undervoltage warning word at 58h defaults to 1.10 times fault level
// R8 - power-good threshold at 5Eh defaults to 0.9 times strapped output voltage
// R9 - turn-on delay word at 60h, reset CA80h, waited before output rise
// R10 - turn-on ramp word at 61h, reset CA80h, used after turn-on delay
// R11 - turn-off delay word at 64h, reset CA80h, waited before output fall
// R12 - turn-off ramp word at 65h, reset CA80h, used after turn-off delay
// R13 - read-only short status at 78h, zero with no fault
// R14 - read-only 16-bit status summary at 79h, zero with no fault
// R15 - read-only input status at 7Ch, zero with no input fault
// R16 - read-only thermal status at 7Dh, zero with no fault or warning
// R17 - read-only comm, logic and memory status at 7Eh, zero with no error
// R18 - read-only driver supply and sync status at 80h, zero with no fault
// R19 - measured input voltage read as linear-eleven word at 88h
// R20 - measured output voltage read as unsigned linear-sixteen word at 8Bh
// R21 - measured output current read as linear-eleven word at 8Ch
// R22 - output voltage exponent fixed at -13; mode byte reads 13h
// R23 - linear-eleven words: 5-bit exponent high, 11-bit signed mantissa low
// R24 - status flags stick until clear-faults; writes to status codes ignored
`timescale 1ns/10ps
module power_module_command_map (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   // command port from the serial bus engine
   input  wire logic                 wr_en_in,
   input  wire logic                 rd_en_in,
   input  wire logic                 send_byte_in,
   input  wire cmd_map_pkg::byte_t   cmd_code_in,
   input  wire cmd_map_pkg::word_t   wr_data_in,
   output logic                      rd_valid_out,
   output cmd_map_pkg::word_t        rd_data_out,
   output logic                      rd_word_out,
   output logic                      cmd_unknown_out,
   // straps sampled at reset release
   input  wire cmd_map_pkg::word_t   strap_vout_in,
   input  wire cmd_map_pkg::word_t   strap_vin_uv_in,
   // fault and warning events from the analog monitors
   input  wire logic [7:0]           vout_event_in,
   input  wire logic [7:0]           iout_event_in,
   input  wire logic [7:0]           input_event_in,
   input  wire logic [7:0]           thermal_event_in,
   input  wire logic [7:0]           cml_event_in,
   input  wire logic [7:0]           drv_sync_event_in,
   // telemetry from the converters
   input  wire cmd_map_pkg::word_t   vin_meas_in,
   input  wire cmd_map_pkg::word_t   vout_meas_in,
   input  wire cmd_map_pkg::word_t   iout_meas_in,
   // settings to the regulation loop
   output cmd_map_pkg::byte_t        ot_fault_action_out,
   output cmd_map_pkg::byte_t        ut_fault_action_out,
   output cmd_map_pkg::byte_t        vin_ov_fault_action_out,
   output cmd_map_pkg::byte_t        vin_uv_fault_action_out,
   output cmd_map_pkg::word_t        ot_warn_level_out,
   output cmd_map_pkg::word_t        ut_warn_level_out,
   output cmd_map_pkg::word_t        ut_fault_level_out,
   output cmd_map_pkg::word_t        vin_ov_fault_level_out,
   output cmd_map_pkg::word_t        vin_ov_warn_level_out,
   output cmd_map_pkg::word_t        vin_uv_warn_level_out,
   output cmd_map_pkg::word_t        vin_uv_fault_level_out,
   output cmd_map_pkg::word_t        good_threshold_out,
   output cmd_map_pkg::word_t        turn_on_delay_time_out,
   output cmd_map_pkg::word_t        ton_ramp_out,
   output cmd_map_pkg::word_t        turn_off_delay_time_out,
   output cmd_map_pkg::word_t        toff_ramp_out
);
   import cmd_map_pkg::*;

   // scale a word by num/den, saturating at the word range
   function automatic word_t scale_word(input word_t v, input logic [4:0] num);
      logic [20:0] prod;
      logic [20:0] quot;
      prod = 21'(v) * 21'(num);
      quot = prod / 21'(SCALE_DEN);
      scale_word = (quot > 21'(16'hFFFF)) ? 16'hFFFF : quot[15:0];
   endfunction : scale_word

   // linear-eleven scaling keeps the exponent and scales the mantissa
   function automatic word_t scale_l11(input word_t v, input logic [4:0] num);
      logic signed [MAN_W-1:0]  man;
      logic signed [MAN_W+5:0]  prod;
      logic signed [MAN_W+5:0]  quot;
      logic [4:0]               ex;
      man  = v[L11_MAN_MSB:0];
      ex   = v[L11_EXP_MSB:L11_EXP_LSB];
      prod = (MAN_W+6)'(man) * $signed({1'b0, num});
      quot = prod / $signed({1'b0, SCALE_DEN});
      if (quot > (MAN_W+6)'(1023)) begin
         quot = (MAN_W+6)'(1023);
      end
      if (quot < -(MAN_W+6)'(1024)) begin
         quot = -(MAN_W+6)'(1024);
      end
      scale_l11 = {ex, quot[MAN_W-1:0]}; // R23
   endfunction : scale_l11

   // read-only status, telemetry and output voltage mode codes
   function automatic logic is_read_only(input byte_t c);
      is_read_only = (c == CODE_SHORT_STATUS) || (c == CODE_FULL_STATUS) ||
                     (c == CODE_VOUT_FLAGS) || (c == CODE_IOUT_FLAGS) ||
                     (c == CODE_INPUT_FLAGS) || (c == CODE_THERMAL_FLAGS) ||
                     (c == CODE_CML_FLAGS) || (c == CODE_DRV_SYNC_FLAGS) ||
                     (c == CODE_VIN_READING) || (c == CODE_VOUT_READING) ||
                     (c == CODE_IOUT_READING) || (c == CODE_VOUT_MODE);
   endfunction : is_read_only

   // configuration registers
   byte_t ot_act_q, ot_act_d, ut_act_q, ut_act_d;
   byte_t ov_act_q, ov_act_d, uv_act_q, uv_act_d;
   word_t ot_warn_q, ot_warn_d, ut_warn_q, ut_warn_d, ut_flt_q, ut_flt_d;
   word_t ov_flt_q, ov_flt_d, ov_warn_q, ov_warn_d;
   word_t uv_warn_q, uv_warn_d, uv_flt_q, uv_flt_d, pg_q, pg_d;
   word_t ton_dly_q, ton_dly_d, turn_on_ramp_time_q, turn_on_ramp_time_d;
   word_t toff_dly_q, toff_dly_d, turn_off_ramp_time_q, turn_off_ramp_time_d;
   logic  strap_pend_q, strap_pend_d;

   // read path
   logic  rd_valid_q, rd_valid_d, rd_word_q, rd_word_d, unk_q, unk_d;
   word_t rd_data_q, rd_data_d;

   flag_bus_if fb ();
   logic [7:0] vout_f, iout_f, in_f, th_f, cml_f, drv_f;
   logic [7:0] short_stat;
   word_t      full_stat;

   assign fb.events = {drv_sync_event_in, cml_event_in, thermal_event_in,
                       input_event_in, iout_event_in, vout_event_in};
   assign fb.clear  = send_byte_in && (cmd_code_in == CODE_CLEAR_FAULTS); // R24
   assign {drv_f, cml_f, th_f, in_f, iout_f, vout_f} = fb.flags;

   sticky_flags sticky_flags_i (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .fb      (fb)
   );

   // summary: one bit per non-empty group, low byte mirrors short status
   assign short_stat = {2'h0, |vout_f, |iout_f, |in_f, |th_f, |cml_f, |drv_f};
   assign full_stat  = {8'h00, short_stat};

   // write decode and strap defaults
   always_comb begin
      ot_act_d     = ot_act_q;
      ut_act_d     = ut_act_q;
      ov_act_d     = ov_act_q;
      uv_act_d     = uv_act_q;
      ot_warn_d    = ot_warn_q;
      ut_warn_d    = ut_warn_q;
      ut_flt_d     = ut_flt_q;
      ov_flt_d     = ov_flt_q;
      ov_warn_d    = ov_warn_q;
      uv_warn_d    = uv_warn_q;
      uv_flt_d     = uv_flt_q;
      pg_d         = pg_q;
      ton_dly_d    = ton_dly_q;
      turn_on_ramp_time_d   = turn_on_ramp_time_q;
      toff_dly_d   = toff_dly_q;
      turn_off_ramp_time_d  = turn_off_ramp_time_q;
      strap_pend_d = 1'b0;
      if (strap_pend_q) begin
         uv_flt_d  = strap_vin_uv_in;
         uv_warn_d = scale_l11(strap_vin_uv_in, UV_WARN_NUM); // R7
         pg_d      = scale_word(strap_vout_in, PG_NUM); // R8
      end else if (wr_en_in && !is_read_only(cmd_code_in)) begin // R24
         unique case (cmd_code_in)
            CODE_OT_FAULT_ACTION:  ot_act_d    = wr_data_in[7:0]; // R1
            CODE_OT_WARN_LEVEL:    ot_warn_d   = wr_data_in; // R2
            CODE_UT_WARN_LEVEL:    ut_warn_d   = wr_data_in; // R3
            CODE_UT_FAULT_LEVEL:   ut_flt_d    = wr_data_in; // R4
            CODE_UT_FAULT_ACTION:  ut_act_d    = wr_data_in[7:0]; // R5
            CODE_VIN_OV_FAULT_LVL: ov_flt_d    = wr_data_in;
            CODE_VIN_OV_FAULT_ACT: ov_act_d    = wr_data_in[7:0];
            CODE_VIN_OV_WARN_LVL:  ov_warn_d   = wr_data_in; // R6
            CODE_VIN_UV_WARN_LVL:  uv_warn_d   = wr_data_in; // R7
            CODE_VIN_UV_FAULT_LVL: uv_flt_d    = wr_data_in;
            CODE_VIN_UV_FAULT_ACT: uv_act_d    = wr_data_in[7:0];
            CODE_GOOD_THRESHOLD:   pg_d        = wr_data_in; // R8
            CODE_TURN_ON_DELAY_TIME_TIME:   ton_dly_d   = wr_data_in; // R9
            CODE_TON_RAMP_TIME:    turn_on_ramp_time_d  = wr_data_in; // R10
            CODE_TURN_OFF_DELAY_TIME_TIME:  toff_dly_d  = wr_data_in; // R11
            CODE_TOFF_RAMP_TIME:   turn_off_ramp_time_d = wr_data_in; // R12
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ot_act_q     <= RST_FAULT_ACTION; // R1
         ut_act_q     <= RST_FAULT_ACTION; // R5
         ov_act_q     <= RST_FAULT_ACTION;
         uv_act_q     <= RST_FAULT_ACTION;
         ot_warn_q    <= RST_OT_WARN_LEVEL; // R2
         ut_warn_q    <= RST_UT_WARN_LEVEL; // R3
         ut_flt_q     <= RST_UT_FAULT_LEVEL; // R4
         ov_flt_q     <= RST_VIN_OV_FAULT_LVL;
         ov_warn_q    <= RST_VIN_OV_WARN_LVL; // R6
         uv_warn_q    <= RST_WORD_ZERO;
         uv_flt_q     <= RST_WORD_ZERO;
         pg_q         <= RST_WORD_ZERO;
         ton_dly_q    <= RST_RAMP_TIME; // R9
         turn_on_ramp_time_q   <= RST_RAMP_TIME; // R10
         toff_dly_q   <= RST_RAMP_TIME; // R11
         turn_off_ramp_time_q  <= RST_RAMP_TIME; // R12
         strap_pend_q <= 1'b1;
      end else begin
         ot_act_q     <= ot_act_d;
         ut_act_q     <= ut_act_d;
         ov_act_q     <= ov_act_d;
         uv_act_q     <= uv_act_d;
         ot_warn_q    <= ot_warn_d;
         ut_warn_q    <= ut_warn_d;
         ut_flt_q     <= ut_flt_d;
         ov_flt_q     <= ov_flt_d;
         ov_warn_q    <= ov_warn_d;
         uv_warn_q    <= uv_warn_d;
         uv_flt_q     <= uv_flt_d;
         pg_q         <= pg_d;
         ton_dly_q    <= ton_dly_d;
         turn_on_ramp_time_q   <= turn_on_ramp_time_d;
         toff_dly_q   <= toff_dly_d;
         turn_off_ramp_time_q  <= turn_off_ramp_time_d;
         strap_pend_q <= strap_pend_d;
      end
   end

   // read mux, answered one cycle after the request
   always_comb begin
      rd_valid_d = rd_en_in;
      rd_word_d  = rd_word_q;
      rd_data_d  = rd_data_q;
      unk_d      = 1'b0;
      if (rd_en_in) begin
         rd_word_d = 1'b1;
         unique case (cmd_code_in)
            CODE_OT_FAULT_ACTION:  begin
               rd_data_d = {8'h00, ot_act_q};
               rd_word_d = 1'b0;
            end
            CODE_OT_WARN_LEVEL:    rd_data_d = ot_warn_q;
            CODE_UT_WARN_LEVEL:    rd_data_d = ut_warn_q;
            CODE_UT_FAULT_LEVEL:   rd_data_d = ut_flt_q;
            CODE_UT_FAULT_ACTION:  begin
               rd_data_d = {8'h00, ut_act_q};
               rd_word_d = 1'b0;
            end
            CODE_VIN_OV_FAULT_LVL: rd_data_d = ov_flt_q;
            CODE_VIN_OV_FAULT_ACT: begin
               rd_data_d = {8'h00, ov_act_q};
               rd_word_d = 1'b0;
            end
            CODE_VIN_OV_WARN_LVL:  rd_data_d = ov_warn_q;
            CODE_VIN_UV_WARN_LVL:  rd_data_d = uv_warn_q;
            CODE_VIN_UV_FAULT_LVL: rd_data_d = uv_flt_q;
            CODE_VIN_UV_FAULT_ACT: begin
               rd_data_d = {8'h00, uv_act_q};
               rd_word_d = 1'b0;
            end
            CODE_GOOD_THRESHOLD:   rd_data_d = pg_q;
            CODE_TURN_ON_DELAY_TIME_TIME:   rd_data_d = ton_dly_q;
            CODE_TON_RAMP_TIME:    rd_data_d = turn_on_ramp_time_q;
            CODE_TURN_OFF_DELAY_TIME_TIME:  rd_data_d = toff_dly_q;
            CODE_TOFF_RAMP_TIME:   rd_data_d = turn_off_ramp_time_q;
            CODE_SHORT_STATUS:     begin
               rd_data_d = {8'h00, short_stat}; // R13
               rd_word_d = 1'b0;
            end
            CODE_FULL_STATUS:      rd_data_d = full_stat; // R14
            CODE_VOUT_FLAGS:       begin
               rd_data_d = {8'h00, vout_f};
               rd_word_d = 1'b0;
            end
            CODE_IOUT_FLAGS:       begin
               rd_data_d = {8'h00, iout_f};
               rd_word_d = 1'b0;
            end
            CODE_INPUT_FLAGS:      begin
               rd_data_d = {8'h00, in_f}; // R15
               rd_word_d = 1'b0;
            end
            CODE_THERMAL_FLAGS:    begin
               rd_data_d = {8'h00, th_f}; // R16
               rd_word_d = 1'b0;
            end
            CODE_CML_FLAGS:        begin
               rd_data_d = {8'h00, cml_f}; // R17
               rd_word_d = 1'b0;
            end
            CODE_DRV_SYNC_FLAGS:   begin
               rd_data_d = {8'h00, drv_f}; // R18
               rd_word_d = 1'b0;
            end
            CODE_VIN_READING:      rd_data_d = vin_meas_in; // R19
            CODE_VOUT_READING:     rd_data_d = vout_meas_in; // R20
            CODE_IOUT_READING:     rd_data_d = iout_meas_in; // R21
            CODE_VOUT_MODE:        begin
               rd_data_d = {8'h00, VOUT_MODE_VALUE}; // R22
               rd_word_d = 1'b0;
            end
            default: begin
               rd_data_d = RST_WORD_ZERO;
               unk_d     = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_valid_q <= 1'b0;
         rd_word_q  <= 1'b0;
         rd_data_q  <= RST_WORD_ZERO;
         unk_q      <= 1'b0;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_word_q  <= rd_word_d;
         rd_data_q  <= rd_data_d;
         unk_q      <= unk_d;
      end
   end

   assign rd_valid_out            = rd_valid_q;
   assign rd_data_out             = rd_data_q;
   assign rd_word_out             = rd_word_q;
   assign cmd_unknown_out         = unk_q;
   assign ot_fault_action_out     = ot_act_q;
   assign ut_fault_action_out     = ut_act_q;
   assign vin_ov_fault_action_out = ov_act_q;
   assign vin_uv_fault_action_out = uv_act_q;
   assign ot_warn_level_out       = ot_warn_q;
   assign ut_warn_level_out       = ut_warn_q;
   assign ut_fault_level_out      = ut_flt_q;
   assign vin_ov_fault_level_out  = ov_flt_q;
   assign vin_ov_warn_level_out   = ov_warn_q;
   assign vin_uv_warn_level_out   = uv_warn_q;
   assign vin_uv_fault_level_out  = uv_flt_q;
   assign good_threshold_out      = pg_q;
   assign turn_on_delay_time_out           = ton_dly_q;
   assign ton_ramp_out            = turn_on_ramp_time_q;
   assign turn_off_delay_time_out          = toff_dly_q;
   assign toff_ramp_out           = turn_off_ramp_time_q;
endmodule : power_module_command_map

// [rtl/sticky_flags.sv]
// sticky status flags, set by events and cleared by a clear command
`timescale 1ns/10ps
module sticky_flags (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rstn_in,
   // flag carrier
   flag_bus_if.hold  fb
);
   import cmd_map_pkg::*;
   localparam int W = NUM_FLAG_GROUPS * 8;
   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // set wins over clear
         always_comb begin
            flags_d[g] = fb.events[g] | (flags_q[g] & ~fb.clear); // R24
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end
   assign fb.flags = flags_q;
endmodule : sticky_flags

// [test/cmd_map_chk.sv]
// concurrent checks on the command map ports
`timescale 1ns/10ps
module cmd_map_chk import cmd_map_pkg::*; (
   // clock and reset
   input wire logic  clk_in,
   input wire logic  rstn_in,
   // command port
   input wire logic  wr_en_in,
   input wire logic  rd_en_in,
   input wire byte_t cmd_code_in,
   input wire word_t wr_data_in,
   input wire logic  rd_valid_out,
   input wire word_t rd_data_out,
   input wire logic  rd_word_out,
   input wire logic  cmd_unknown_out,
   // settings
   input wire word_t turn_on_delay_time_out,
   input wire byte_t ot_fault_action_out,
   input wire word_t good_threshold_out,
   input wire word_t vin_uv_warn_level_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   rd_answer_a: assert property (rd_en_in |=> rd_valid_out)
      else $error("read not answered next cycle");
   rd_cause_a: assert property (rd_valid_out |-> $past(rd_en_in))
      else $error("read answer without request");
   unk_zero_a: assert property (cmd_unknown_out |-> rd_valid_out && rd_data_out == 16'h0000)
      else $error("unmapped read not zero");
   ton_wr_a: assert property (wr_en_in && cmd_code_in == CODE_TURN_ON_DELAY_TIME_TIME
      |=> turn_on_delay_time_out == $past(wr_data_in)) else $error("turn-on delay not written");
   ot_act_a: assert property (wr_en_in && cmd_code_in == CODE_OT_FAULT_ACTION
      |=> ot_fault_action_out == byte_t'($past(wr_data_in))) else $error("action not written");
   short_byte_a: assert property (rd_en_in && cmd_code_in == CODE_SHORT_STATUS
      |=> !rd_word_out && rd_data_out[15:8] == 8'h00) else $error("short status not a byte");
   full_word_a: assert property (rd_en_in && cmd_code_in == CODE_FULL_STATUS
      |=> rd_word_out && rd_data_out[15:8] == 8'h00) else $error("status word wrong");
   mode_read_a: assert property (rd_en_in && cmd_code_in == CODE_VOUT_MODE
      |=> rd_data_out == 16'h0013) else $error("mode byte wrong");
   data_hold_a: assert property (!rd_valid_out |-> $stable(rd_data_out))
      else $error("read data moved without read");
   pg_out_a: assert property (rd_en_in && !wr_en_in && cmd_code_in == CODE_GOOD_THRESHOLD
      |=> rd_data_out == good_threshold_out) else $error("threshold readback differs");
   uv_out_a: assert property (rd_en_in && !wr_en_in && cmd_code_in == CODE_VIN_UV_WARN_LVL
      |=> rd_data_out == vin_uv_warn_level_out) else $error("warning readback differs");
   cover property (rd_valid_out && rd_word_out);
   cover property (cmd_unknown_out);
   cover property (wr_en_in && cmd_code_in == CODE_TURN_ON_DELAY_TIME_TIME);
endmodule : cmd_map_chk

// [test/pmbus_host_model.sv]
// host-side model issuing command map requests
`timescale 1ns/10ps
module pmbus_host_model import cmd_map_pkg::*; (
   // clock
   input  wire logic clk_in,
   // request lines
   output logic      wr_en_out,
   output logic      rd_en_out,
   output logic      send_byte_out,
   output byte_t     code_out,
   output word_t     data_out
);
   logic [17:0] exp_q[$];
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      send_byte_out = 1'b0;
      code_out = 8'h00;
      data_out = 16'h0000;
   end
   // kind 0 write, 1 read, 2 send byte
   task automatic issue(input int kind, input byte_t code, input word_t data,
                        input logic [17:0] exp);
      @(posedge clk_in);
      wr_en_out     <= (kind == 0);
      rd_en_out     <= (kind == 1);
      send_byte_out <= (kind == 2);
      code_out      <= code;
      data_out      <= data;
      if (kind == 1) exp_q.push_back(exp);
      @(posedge clk_in);
      {wr_en_out, rd_en_out, send_byte_out} <= 3'b000;
      // idle lines do not keep the last value
      code_out <= ~code;
      data_out <= ~data;
   endtask : issue
endmodule : pmbus_host_model

// [test/power_module_command_map_tb_top.sv]
// self-checking bench for the command map
`timescale 1ns/10ps
bind power_module_command_map cmd_map_chk cmd_map_chk_i (.clk_in, .rstn_in, .wr_en_in,
   .rd_en_in, .cmd_code_in, .wr_data_in, .rd_valid_out, .rd_data_out, .rd_word_out,
   .cmd_unknown_out, .turn_on_delay_time_out, .ot_fault_action_out, .good_threshold_out,
   .vin_uv_warn_level_out);
module power_module_command_map_tb_top;
   import cmd_map_pkg::*;
   logic  clk_in = 1'b0;
   logic  rstn_in, wr_en, rd_en, sb, rd_valid_out, rd_word_out, cmd_unknown_out;
   byte_t code;
   word_t wdata, rd_data_out, vin_m, vout_m, iout_m, strap_vout, strap_uv, d;
   logic [47:0] ev;
   logic [17:0] w;
   int    err_total, comparisons;
   byte_t rw_code[13] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
                          8'h5A, 8'h60, 8'h61, 8'h64, 8'h65};
   word_t rw_def[13] = '{16'h0080, 16'hEB70, 16'hDC40, 16'hE530, 16'h0080, 16'hD3A0,
                         16'h0080, 16'hD34D, 16'h0080, 16'hCA80, 16'hCA80, 16'hCA80, 16'hCA80};
   byte_t st_code[8] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
   always #5 clk_in = ~clk_in;
   pmbus_host_model pmbus_host_model_i (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
      .send_byte_out(sb), .code_out(code), .data_out(wdata));
   power_module_command_map power_module_command_map_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .send_byte_in(sb), .cmd_code_in(code),
      .wr_data_in(wdata), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .rd_word_out(rd_word_out), .cmd_unknown_out(cmd_unknown_out),
      .strap_vout_in(strap_vout), .strap_vin_uv_in(strap_uv),
      .vout_event_in(ev[7:0]), .iout_event_in(ev[15:8]), .input_event_in(ev[23:16]),
      .thermal_event_in(ev[31:24]), .cml_event_in(ev[39:32]), .drv_sync_event_in(ev[47:40]),
      .vin_meas_in(vin_m), .vout_meas_in(vout_m), .iout_meas_in(iout_m),
      .ot_fault_action_out(), .ut_fault_action_out(), .vin_ov_fault_action_out(),
      .vin_uv_fault_action_out(), .ot_warn_level_out(), .ut_warn_level_out(),
      .ut_fault_level_out(), .vin_ov_fault_level_out(), .vin_ov_warn_level_out(),
      .vin_uv_warn_level_out(), .vin_uv_fault_level_out(), .good_threshold_out(),
      .turn_on_delay_time_out(), .ton_ramp_out(), .turn_off_delay_time_out(), .toff_ramp_out());
   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("FAIL %0t read %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic rd(input byte_t c, input word_t v, input logic wd);
      pmbus_host_model_i.issue(1, c, 16'h0000, {1'b0, wd, v});
   endtask : rd
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // oldest note against each answer
   always @(negedge clk_in) begin
      if (rd_valid_out === 1'b1) begin
         w = (pmbus_host_model_i.exp_q.size() > 0) ? pmbus_host_model_i.exp_q.pop_front()
                                                    : 18'h3FFFF;
         check({cmd_unknown_out, rd_word_out & ~w[17], rd_data_out}, w);
      end
   end
   initial begin
      #50000;
      err_total++;
      conclude();
   end
   initial begin
      void'($urandom(87));
      err_total = 0;
      comparisons = 0;
      rstn_in = 1'b0;
      ev = '0;
      strap_vout = 16'h2000;
      strap_uv = 16'hD280;
      vin_m = 16'($urandom);
      vout_m = 16'($urandom);
      iout_m = 16'($urandom);
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      for (int i = 0; i < 13; i++) rd(rw_code[i], rw_def[i], rw_def[i] != 16'h0080);
      rd(8'h59, 16'hD280, 1'b1);
      rd(8'h58, 16'hD2C0, 1'b1);
      rd(8'h5E, 16'h1CCC, 1'b1);
      rd(8'h20, 16'h0013, 1'b0);
      for (int i = 0; i < 8; i++) rd(st_code[i], 16'h0000, i == 1);
      for (int i = 0; i < 13; i++) begin
         d = 16'($urandom);
         pmbus_host_model_i.issue(0, rw_code[i], d, 18'h0);
         rd(rw_code[i], rw_def[i] == 16'h0080 ? {8'h00, d[7:0]} : d, rw_def[i] != 16'h0080);
      end
      for (int i = 0; i < 8; i++) begin
         pmbus_host_model_i.issue(0, st_code[i], 16'($urandom), 18'h0);
         rd(st_code[i], 16'h0000, i == 1);
      end
      pmbus_host_model_i.issue(0, 8'h88, 16'($urandom), 18'h0);
      rd(8'h88, vin_m, 1'b1);
      rd(8'h8B, vout_m, 1'b1);
      rd(8'h8C, iout_m, 1'b1);
      pmbus_host_model_i.issue(1, 8'h99, 16'h0000, {1'b1, 1'b0, 16'h0000});
      for (int g = 0; g < 6; g++) begin
         @(posedge clk_in);
         ev <= 48'h1 << (g * 9);
         @(posedge clk_in);
         ev <= '0;
         repeat (2) @(posedge clk_in);
         rd(st_code[g + 2], 16'h0001 << g, 1'b0);
         rd(8'h78, 16'h0001 << (5 - g), 1'b0);
         rd(8'h79, 16'h0001 << (5 - g), 1'b1);
         rd(st_code[g + 2], 16'h0001 << g, 1'b0);
         pmbus_host_model_i.issue(2, CODE_CLEAR_FAULTS, 16'h0000, 18'h0);
         rd(st_code[g + 2], 16'h0000, 1'b0);
         rd(8'h79, 16'h0000, 1'b1);
      end
      repeat (4) @(posedge clk_in);
      conclude();
   end
endmodule : power_module_command_map_tb_top
